/* hdl/pgs_top.sv */
// Gain scheduler and regulator supervision for the process regulator.
// Assumes settings are static levels; terminal inputs are asynchronous pins.
module pgs_top
    import pgs_pkg::*;
#(
    parameter int TICK_CNT = TICK_CYCLES   // Cycles per control tick.
)(
    // Clock and reset.
    input  wire logic              SYS_CLK_I,
    input  wire logic              RST_B_I,
    // Drive state and terminals.
    input  wire logic              RUN_I,            // Drive running.
    input  wire logic              GAIN_SWITCH_IN_I, // Gain-switch terminal.
    input  wire logic              INT_PAUSE_IN_I,   // Integral-pause terminal.
    // Process values.
    input  wire logic [PCT_W-1:0]  SETPOINT_I,
    input  wire logic [PCT_W-1:0]  FEEDBACK_I,
    input  wire logic              OUT_AT_LIMIT_I,   // Regulator output at max or min.
    // Gain sets.
    input  wire logic [GAIN_W-1:0] FIRST_PROPORTIONAL_GAIN_I,
    input  wire logic [GAIN_W-1:0] FIRST_INTEGRAL_TIME_I,
    input  wire logic [GAIN_W-1:0] FIRST_DERIVATIVE_TIME_I,
    input  wire logic [GAIN_W-1:0] SECOND_PROPORTIONAL_GAIN_I,
    input  wire logic [GAIN_W-1:0] SECOND_INTEGRAL_TIME_I,
    input  wire logic [GAIN_W-1:0] SECOND_DERIVATIVE_TIME_I,
    // Scheduling settings.
    input  wire logic [1:0]        GAIN_SWITCH_CONDITION_I,
    input  wire logic [PCT_W-1:0]  LOWER_SWITCH_THRESHOLD_I,
    input  wire logic [PCT_W-1:0]  UPPER_SWITCH_THRESHOLD_I,
    input  wire logic [PCT_W-1:0]  STARTUP_OUTPUT_VALUE_I,
    input  wire logic [TIME_W-1:0] STARTUP_HOLD_TIME_I,  // 10 ms units.
    input  wire logic [7:0]        INTEGRAL_ATTRIBUTE_CODE_I, // Two BCD digits.
    input  wire logic [PCT_W-1:0]  FEEDBACK_LOSS_LEVEL_I,
    input  wire logic [TIME_W-1:0] FEEDBACK_LOSS_TIME_I,     // 10 ms units.
    input  wire logic              STOPPED_COMPUTE_SELECT_I,
    // Results.
    output logic [GAIN_W-1:0]      GAIN_KP_O,
    output logic [GAIN_W-1:0]      GAIN_TI_O,
    output logic [GAIN_W-1:0]      GAIN_TD_O,
    output logic                   INTEGRATE_EN_O,   // Integral may accumulate.
    output logic                   INTEGRAL_USE_O,   // Integral term contributes.
    output logic                   COMPUTE_EN_O,     // Regulator computes.
    output logic                   OUTPUT_FORCE_O,   // Output forced to initial value.
    output logic [PCT_W-1:0]       FORCE_VALUE_O,
    output logic                   FEEDBACK_LOSS_FAULT_O
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] sw_meta_r, sw_sync_r;  // Bit0 gain switch, bit1 pause.
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            sw_meta_r <= 2'h0;
            sw_sync_r <= 2'h0;
        end else begin
            sw_meta_r <= {INT_PAUSE_IN_I, GAIN_SWITCH_IN_I};
            sw_sync_r <= sw_meta_r;
        end
    end
    wire gain_sw  = sw_sync_r[0];
    wire int_paus = sw_sync_r[1];

    // ------------------------------------------------------------------
    // Control tick divider
    // ------------------------------------------------------------------
    logic [31:0] div_r;
    logic        tick_r;
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            div_r  <= 32'h0;
            tick_r <= 1'b0;
        end else if (div_r == 32'(TICK_CNT - 1)) begin
            div_r  <= 32'h0;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + 32'h1;
            tick_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Threshold clamping and deviation
    // ------------------------------------------------------------------
    // Upper is capped at full scale, lower at the upper threshold.
    wire [PCT_W-1:0] thr_hi = (UPPER_SWITCH_THRESHOLD_I > PCT_FULL) ?
                              PCT_FULL : UPPER_SWITCH_THRESHOLD_I;
    wire [PCT_W-1:0] thr_lo = (LOWER_SWITCH_THRESHOLD_I > thr_hi) ?
                              thr_hi : LOWER_SWITCH_THRESHOLD_I;
    wire [PCT_W-1:0] dev    = (SETPOINT_I >= FEEDBACK_I) ? (SETPOINT_I - FEEDBACK_I)
                                                         : (FEEDBACK_I - SETPOINT_I);
    wire [PCT_W-1:0] span   = thr_hi - thr_lo;
    wire [PCT_W-1:0] over   = dev - thr_lo;
    // Fraction of set two between thresholds, in 0.1 % of full weight.
    // Both factors are widened first so the product keeps all twenty bits.
    wire [2*PCT_W-1:0] prod = (2*PCT_W)'(over) * (2*PCT_W)'(PCT_FULL);
    wire [PCT_W-1:0]   ramp = (span == PCT_ZERO) ? PCT_FULL : PCT_W'(prod / span);

    // ------------------------------------------------------------------
    // Policy selection
    // ------------------------------------------------------------------
    pgs_sw_t cond;
    assign cond = pgs_sw_t'(GAIN_SWITCH_CONDITION_I);
    logic [PCT_W-1:0] frac_sel;
    always_comb begin
        case (cond)
            SW_TERMINAL: frac_sel = gain_sw ? PCT_FULL : PCT_ZERO;
            SW_DEVIATE: begin
                if (dev < thr_lo) begin
                    frac_sel = PCT_ZERO;
                end else if (dev > thr_hi) begin
                    frac_sel = PCT_FULL;
                end else begin
                    frac_sel = ramp;
                end
            end
            default:     frac_sel = PCT_ZERO;
        endcase
    end

    // ------------------------------------------------------------------
    // Gain blenders, one per gain
    // ------------------------------------------------------------------
    pgs_gain_if g_kp ();
    pgs_gain_if g_ti ();
    pgs_gain_if g_td ();
    assign g_kp.a_val = FIRST_PROPORTIONAL_GAIN_I;
    assign g_kp.b_val = SECOND_PROPORTIONAL_GAIN_I;
    assign g_ti.a_val = FIRST_INTEGRAL_TIME_I;
    assign g_ti.b_val = SECOND_INTEGRAL_TIME_I;
    assign g_td.a_val = FIRST_DERIVATIVE_TIME_I;
    assign g_td.b_val = SECOND_DERIVATIVE_TIME_I;
    assign g_kp.frac  = frac_sel;
    assign g_ti.frac  = frac_sel;
    assign g_td.frac  = frac_sel;
    pgs_blend u_kp (.sys_clk_i(SYS_CLK_I), .rst_b_i(RST_B_I), .g(g_kp));
    pgs_blend u_ti (.sys_clk_i(SYS_CLK_I), .rst_b_i(RST_B_I), .g(g_ti));
    pgs_blend u_td (.sys_clk_i(SYS_CLK_I), .rst_b_i(RST_B_I), .g(g_td));

    // ------------------------------------------------------------------
    // Integral attribute decode
    // ------------------------------------------------------------------
    wire sep_en   = (INTEGRAL_ATTRIBUTE_CODE_I[3:0] == ATTR_ON);
    wire limit_st = (INTEGRAL_ATTRIBUTE_CODE_I[7:4] == ATTR_ON);
    wire paused   = sep_en & int_paus;
    wire frozen   = limit_st & OUT_AT_LIMIT_I;

    // ------------------------------------------------------------------
    // Start-up hold sequence
    // ------------------------------------------------------------------
    pgs_state_t st_r, st_nxt;
    logic [TIME_W-1:0] hold_r, hold_nxt;
    always_comb begin
        st_nxt   = st_r;
        hold_nxt = hold_r;
        case (st_r)
            ST_IDLE: if (RUN_I) begin
                st_nxt   = (STARTUP_HOLD_TIME_I == '0) ? ST_RUN : ST_HOLD;
                hold_nxt = '0;
            end
            ST_HOLD: begin
                if (!RUN_I) begin
                    st_nxt = ST_IDLE;
                end else if (tick_r) begin
                    hold_nxt = hold_r + TIME_W'(1);
                    if (hold_nxt >= STARTUP_HOLD_TIME_I) begin
                        st_nxt = ST_RUN;
                    end
                end
            end
            ST_RUN:  if (!RUN_I) begin
                st_nxt = ST_IDLE;
            end
            default: st_nxt = ST_IDLE;
        endcase
    end
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            st_r   <= ST_IDLE;
            hold_r <= '0;
        end else begin
            st_r   <= st_nxt;
            hold_r <= hold_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Feedback loss timer
    // ------------------------------------------------------------------
    logic [TIME_W-1:0] loss_r;
    logic              fault_r;
    wire det_en  = (FEEDBACK_LOSS_LEVEL_I != PCT_ZERO);
    wire fb_low  = det_en & (FEEDBACK_I < FEEDBACK_LOSS_LEVEL_I);
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            loss_r  <= '0;
            fault_r <= 1'b0;
        end else if (!fb_low) begin
            loss_r  <= '0;
        end else if (tick_r) begin
            if (loss_r > FEEDBACK_LOSS_TIME_I) begin
                fault_r <= 1'b1;
            end else begin
                loss_r <= loss_r + TIME_W'(1);
            end
        end
    end

    // ------------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------------
    wire compute = RUN_I | STOPPED_COMPUTE_SELECT_I;
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            COMPUTE_EN_O   <= 1'b0;
            INTEGRATE_EN_O <= 1'b0;
            INTEGRAL_USE_O <= 1'b1;
            OUTPUT_FORCE_O <= 1'b0;
            FORCE_VALUE_O  <= PCT_ZERO;
        end else begin
            COMPUTE_EN_O   <= compute;
            INTEGRATE_EN_O <= compute & ~paused & ~frozen;
            INTEGRAL_USE_O <= ~paused;
            OUTPUT_FORCE_O <= (st_nxt == ST_HOLD);
            FORCE_VALUE_O  <= STARTUP_OUTPUT_VALUE_I;
        end
    end
    assign GAIN_KP_O = g_kp.mix;
    assign GAIN_TI_O = g_ti.mix;
    assign GAIN_TD_O = g_td.mix;
    assign FEEDBACK_LOSS_FAULT_O = fault_r;
endmodule

/* hdl/pgs_pkg.sv */
// Constants, field codes and timing counts for the regulator gain scheduler.
// Assumes a single 40 MHz system clock and a control tick derived inside the block.
//
// Operation
// - Terminal switching: input inactive set one, active set two
// - Automatic: deviation below lower threshold uses set one
// - Automatic: deviation above upper threshold uses set two
// - Between thresholds gains blend linearly
// - Lower threshold clamped to upper, upper clamped to 100%
// - Switch-condition selector chooses policy, default zero
// - Set two holds own gain, integral, derivative
// - After start output held at initial value for hold time
// - Separation enabled: pause input halts integration
// - Separation disabled: pause input ignored
// - Stop-at-limit freezes integral at output extremes
// - Attribute code: units separation, tens limit stop
// - Feedback low too long raises loss fault
// - Loss level zero disables loss detection
// - Set one used when set two not selected
package pgs_pkg;

    // ------------------------------------------------------------------
    // Scaling and widths
    // ------------------------------------------------------------------
    localparam int PCT_W = 10;                       // Percent in 0.1 % steps.
    localparam logic [PCT_W-1:0] PCT_FULL = 10'h3E8; // 100.0 %.
    localparam logic [PCT_W-1:0] PCT_ZERO = 10'h000; // 0.0 %.
    localparam int GAIN_W = 16;                      // Gain/time fields.
    localparam int TIME_W = 16;                      // Times in 10 ms ticks.

    // ------------------------------------------------------------------
    // Reset values of settings
    // ------------------------------------------------------------------
    localparam logic [PCT_W-1:0]  LOW_THR_RST  = 10'h0C8;   // 20.0 %.
    localparam logic [PCT_W-1:0]  HIGH_THR_RST = 10'h320;   // 80.0 %.
    localparam logic [GAIN_W-1:0] KP_RST       = 16'h00C8;  // 20.0.
    localparam logic [GAIN_W-1:0] TI_RST       = 16'h00C8;  // 2.00 s.
    localparam logic [GAIN_W-1:0] TD_RST       = 16'h0000;  // 0.000 s.

    // ------------------------------------------------------------------
    // Switch condition codes and attribute fields
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SW_NONE     = 2'b00,   // Set one only.
        SW_TERMINAL = 2'b01,   // Gain-switch input selects.
        SW_DEVIATE  = 2'b10    // Deviation magnitude selects.
    } pgs_sw_t;
    localparam logic [3:0] ATTR_OFF = 4'h0;         // Digit value off.
    localparam logic [3:0] ATTR_ON  = 4'h1;         // Digit value on.

    // ------------------------------------------------------------------
    // Timing: control tick of 10 ms from the 40 MHz clock
    // ------------------------------------------------------------------
    localparam int CLK_HZ      = 40000000;
    localparam int TICK_MS     = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // Start-up sequence states.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HOLD = 2'b01,
        ST_RUN  = 2'b10
    } pgs_state_t;

endpackage

/* hdl/pgs_gain_if.sv */
// Interface carrying one blended gain between the scheduler and the blender.
// Assumes both ends sit on the same clock.
interface pgs_gain_if;
    import pgs_pkg::*;
    logic [GAIN_W-1:0] a_val;   // Set one value.
    logic [GAIN_W-1:0] b_val;   // Set two value.
    logic [PCT_W-1:0]  frac;    // Weight of set two, 0..PCT_FULL.
    logic [GAIN_W-1:0] mix;     // Registered blended value.
    modport ctrl  (output a_val, output b_val, output frac, input mix);
    modport blend (input a_val, input b_val, input frac, output mix);
endinterface

/* hdl/pgs_blend.sv */
// Linear blend of one gain between set one and set two, registered output.
// Assumes frac never exceeds PCT_FULL.
module pgs_blend
    import pgs_pkg::*;
(
    // Clock and reset.
    input  wire logic   sys_clk_i,
    input  wire logic   rst_b_i,
    // Gain pair and weight.
    pgs_gain_if.blend   g
);
    // ------------------------------------------------------------------
    // Interpolation
    // ------------------------------------------------------------------
    // Weighted sum is kept wide so the product never wraps.
    logic [GAIN_W+PCT_W:0] sum_w;
    logic [GAIN_W-1:0]     mix_nxt;
    // Operands are widened before the multiply, since a product keeps only the width of its operands.
    assign sum_w   = (GAIN_W+PCT_W+1)'(g.a_val) * (GAIN_W+PCT_W+1)'(PCT_FULL - g.frac)
                   + (GAIN_W+PCT_W+1)'(g.b_val) * (GAIN_W+PCT_W+1)'(g.frac);
    assign mix_nxt = GAIN_W'(sum_w / PCT_FULL);

    // Register the blended value.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            g.mix <= KP_RST;
        end else begin
            g.mix <= mix_nxt;
        end
    end
endmodule

/* bench/pgs_sva.sv */
// Concurrent checks on the gain scheduler ports.
// Assumes one clock and a synchronous active-low reset.
module pgs_sva
    import pgs_pkg::*;
#(
    parameter int TICK_CNT = TICK_CYCLES  // Cycles per control tick.
)(
    // Clock, reset, drive state and terminals.
    input wire logic              SYS_CLK_I, RST_B_I, RUN_I, GAIN_SWITCH_IN_I, INT_PAUSE_IN_I,
    input wire logic              OUT_AT_LIMIT_I, STOPPED_COMPUTE_SELECT_I,
    // Process values and settings.
    input wire logic [PCT_W-1:0]  SETPOINT_I, FEEDBACK_I, FEEDBACK_LOSS_LEVEL_I,
    input wire logic [PCT_W-1:0]  LOWER_SWITCH_THRESHOLD_I, UPPER_SWITCH_THRESHOLD_I,
    input wire logic [GAIN_W-1:0] FIRST_PROPORTIONAL_GAIN_I, SECOND_PROPORTIONAL_GAIN_I,
    input wire logic [1:0]        GAIN_SWITCH_CONDITION_I,
    input wire logic [TIME_W-1:0] STARTUP_HOLD_TIME_I,
    input wire logic [7:0]        INTEGRAL_ATTRIBUTE_CODE_I,
    // Results.
    input wire logic [GAIN_W-1:0] GAIN_KP_O,
    input wire logic              INTEGRATE_EN_O, INTEGRAL_USE_O, COMPUTE_EN_O,
    input wire logic              OUTPUT_FORCE_O, FEEDBACK_LOSS_FAULT_O
);
    timeunit 1ns;
    timeprecision 100ps;
    // Magnitude of the setpoint to feedback deviation.
    wire logic [PCT_W-1:0] dev = (SETPOINT_I > FEEDBACK_I) ? SETPOINT_I - FEEDBACK_I : FEEDBACK_I - SETPOINT_I;
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);

    // The reset level in an antecedent keeps the edge that releases reset out of the checks.
    a_compute_follows: assert property (RST_B_I
        |=> COMPUTE_EN_O == $past(RUN_I || STOPPED_COMPUTE_SELECT_I))
        else $error("Compute enable does not follow run and stop selector.");
    a_fixed_set_one: assert property ((RST_B_I
        && GAIN_SWITCH_CONDITION_I[0] == GAIN_SWITCH_CONDITION_I[1])
        |=> GAIN_KP_O == $past(FIRST_PROPORTIONAL_GAIN_I)) else $error("Set one not used without switching.");
    a_terminal_set_two: assert property ((GAIN_SWITCH_CONDITION_I == 2'h1 && GAIN_SWITCH_IN_I
        && $stable(SECOND_PROPORTIONAL_GAIN_I))[*4] |-> GAIN_KP_O == SECOND_PROPORTIONAL_GAIN_I)
        else $error("Active gain terminal did not select set two.");
    a_dev_low_one: assert property ((RST_B_I && GAIN_SWITCH_CONDITION_I == 2'h2
        && dev < LOWER_SWITCH_THRESHOLD_I && LOWER_SWITCH_THRESHOLD_I <= UPPER_SWITCH_THRESHOLD_I
        && UPPER_SWITCH_THRESHOLD_I <= PCT_FULL) |=> GAIN_KP_O == $past(FIRST_PROPORTIONAL_GAIN_I))
        else $error("Small deviation did not select set one.");
    a_dev_high_two: assert property ((GAIN_SWITCH_CONDITION_I == 2'h2 && dev > UPPER_SWITCH_THRESHOLD_I)
        |=> GAIN_KP_O == $past(SECOND_PROPORTIONAL_GAIN_I)) else $error("Large deviation did not select set two.");
    a_pause_halts: assert property ((INTEGRAL_ATTRIBUTE_CODE_I[3:0] == 4'h1 && INT_PAUSE_IN_I)[*4]
        |-> !INTEGRAL_USE_O && !INTEGRATE_EN_O) else $error("Pause with separation on kept the integral.");
    a_sep_off_runs: assert property ((INTEGRAL_ATTRIBUTE_CODE_I == 8'h00 && RUN_I)
        |=> INTEGRATE_EN_O && INTEGRAL_USE_O) else $error("Integral stopped with all attributes off.");
    a_limit_freezes: assert property ((INTEGRAL_ATTRIBUTE_CODE_I[7:4] == 4'h1 && OUT_AT_LIMIT_I)
        |=> !INTEGRATE_EN_O) else $error("Integral kept running at the output limit.");
    a_start_forces: assert property (($rose(RUN_I) && STARTUP_HOLD_TIME_I != 16'h0000) |=> OUTPUT_FORCE_O)
        else $error("Start did not force the initial output.");
    a_loss_disabled: assert property ((FEEDBACK_LOSS_LEVEL_I == 10'h000 && !FEEDBACK_LOSS_FAULT_O)
        |=> !FEEDBACK_LOSS_FAULT_O) else $error("Loss fault raised with detection off.");
endmodule

bind pgs_top pgs_sva #(.TICK_CNT(TICK_CNT)) pgs_sva_inst (.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I),
    .RUN_I(RUN_I), .GAIN_SWITCH_IN_I(GAIN_SWITCH_IN_I), .INT_PAUSE_IN_I(INT_PAUSE_IN_I),
    .OUT_AT_LIMIT_I(OUT_AT_LIMIT_I), .STOPPED_COMPUTE_SELECT_I(STOPPED_COMPUTE_SELECT_I),
    .SETPOINT_I(SETPOINT_I), .FEEDBACK_I(FEEDBACK_I), .FEEDBACK_LOSS_LEVEL_I(FEEDBACK_LOSS_LEVEL_I),
    .LOWER_SWITCH_THRESHOLD_I(LOWER_SWITCH_THRESHOLD_I), .UPPER_SWITCH_THRESHOLD_I(UPPER_SWITCH_THRESHOLD_I),
    .FIRST_PROPORTIONAL_GAIN_I(FIRST_PROPORTIONAL_GAIN_I), .SECOND_PROPORTIONAL_GAIN_I(SECOND_PROPORTIONAL_GAIN_I),
    .GAIN_SWITCH_CONDITION_I(GAIN_SWITCH_CONDITION_I), .STARTUP_HOLD_TIME_I(STARTUP_HOLD_TIME_I),
    .INTEGRAL_ATTRIBUTE_CODE_I(INTEGRAL_ATTRIBUTE_CODE_I), .GAIN_KP_O(GAIN_KP_O), .INTEGRATE_EN_O(INTEGRATE_EN_O),
    .INTEGRAL_USE_O(INTEGRAL_USE_O), .COMPUTE_EN_O(COMPUTE_EN_O), .OUTPUT_FORCE_O(OUTPUT_FORCE_O),
    .FEEDBACK_LOSS_FAULT_O(FEEDBACK_LOSS_FAULT_O));

/* bench/pgs_term_model.sv */
// Model of the input terminals that feed the scheduler.
// Assumes the bench asks for terminal levels on plain request ports.
module pgs_term_model (
    // Bench clock and requested levels.
    input  wire logic clk_i,
    input  wire logic gain_req_i,
    input  wire logic pause_req_i,
    // Terminal pins toward the block.
    output logic      gain_pin_o,
    output logic      pause_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Pins start inactive and move 7 ns after an edge, unrelated to sampling.
    initial begin
        gain_pin_o = 1'b0;
        pause_pin_o = 1'b0;
    end
    always @(posedge clk_i) begin
        #7;
        gain_pin_o = gain_req_i;
        pause_pin_o = pause_req_i;
    end
endmodule

/* bench/tb_top.sv */
// Self-checking bench for the gain scheduler top module.
// Assumes a 40 MHz clock and a four-cycle control tick.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import pgs_pkg::*;
    localparam int TCK = 4;  // Short control tick.
    // Stimulus, all driven from time zero.
    logic clk = 1'b0, rst_b = 1'b0, run = 1'b0, greq = 1'b0, preq = 1'b0, lim = 1'b0, stsel = 1'b0;
    logic [PCT_W-1:0] sp = 10'h000, fb = 10'h000, lo = LOW_THR_RST, hi = HIGH_THR_RST, iv = 10'h000, lvl = 10'h000;
    logic [GAIN_W-1:0] kp1 = 16'h0100, ti1 = 16'h0064, td1 = 16'h0010;
    logic [GAIN_W-1:0] kp2 = 16'h0300, ti2 = 16'h012C, td2 = 16'h0030;
    logic [TIME_W-1:0] hold = 16'h0000, ltime = 16'h0002;
    logic [1:0] cond = 2'h0;
    logic [7:0] attr = 8'h00;
    // Observed results.
    logic gsw, pause, int_en, int_use, comp_en, force_o, fault;
    logic [GAIN_W-1:0] kp_o, ti_o, td_o;
    logic [PCT_W-1:0] force_v;
    int error_cnt = 0, checks_done = 0;

    always #12.5 clk = ~clk;

    pgs_term_model pgs_term_model_inst (.clk_i(clk), .gain_req_i(greq), .pause_req_i(preq),
        .gain_pin_o(gsw), .pause_pin_o(pause));
    pgs_top #(.TICK_CNT(TCK)) pgs_top_inst (.SYS_CLK_I(clk), .RST_B_I(rst_b), .RUN_I(run),
        .GAIN_SWITCH_IN_I(gsw), .INT_PAUSE_IN_I(pause), .SETPOINT_I(sp), .FEEDBACK_I(fb), .OUT_AT_LIMIT_I(lim),
        .FIRST_PROPORTIONAL_GAIN_I(kp1), .FIRST_INTEGRAL_TIME_I(ti1), .FIRST_DERIVATIVE_TIME_I(td1),
        .SECOND_PROPORTIONAL_GAIN_I(kp2), .SECOND_INTEGRAL_TIME_I(ti2), .SECOND_DERIVATIVE_TIME_I(td2),
        .GAIN_SWITCH_CONDITION_I(cond), .LOWER_SWITCH_THRESHOLD_I(lo), .UPPER_SWITCH_THRESHOLD_I(hi),
        .STARTUP_OUTPUT_VALUE_I(iv), .STARTUP_HOLD_TIME_I(hold), .INTEGRAL_ATTRIBUTE_CODE_I(attr),
        .FEEDBACK_LOSS_LEVEL_I(lvl), .FEEDBACK_LOSS_TIME_I(ltime), .STOPPED_COMPUTE_SELECT_I(stsel),
        .GAIN_KP_O(kp_o), .GAIN_TI_O(ti_o), .GAIN_TD_O(td_o), .INTEGRATE_EN_O(int_en), .INTEGRAL_USE_O(int_use),
        .COMPUTE_EN_O(comp_en), .OUTPUT_FORCE_O(force_o), .FORCE_VALUE_O(force_v), .FEEDBACK_LOSS_FAULT_O(fault));

    // Waits for a number of rising edges.
    task step(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Compares one result and counts it.
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected blend with both thresholds clamped first.
    function automatic logic [15:0] mixv(input int a, input int b, input int d, input int l, input int h);
        int f;
        if (h > 1000) h = 1000;
        if (l > h) l = h;
        if (d < l) f = 0;
        else if (d > h || h == l) f = 1000;
        else f = (d - l) * 1000 / (h - l);
        return 16'((a * (1000 - f) + b * f) / 1000);
    endfunction
    // Prints the counts and the verdict, then stops.
    task give_verdict;
        $display("Checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Holds reset for 13 cycles and checks the reset values.
    task t_reset;
        step(1);
        rst_b <= 1'b0;
        step(12);
        #1 chk(kp_o, KP_RST);
        chk(16'(int_use), 16'h0001);
        chk(16'(fault), 16'h0000);
        step(1);
        rst_b <= 1'b1;
        step(3);
        $display("Test reset done");
    endtask
    // Fixed set one, then the gain-switch terminal.
    task t_gains;
        step(1);
        greq <= 1'b1;
        step(5);
        #1 chk(kp_o, kp1);
        step(1);
        cond <= 2'h3;
        step(2);
        #1 chk(td_o, td1);
        step(1);
        cond <= 2'h1;
        step(5);
        #1 chk(kp_o, kp2);
        chk(ti_o, ti2);
        chk(td_o, td2);
        step(1);
        greq <= 1'b0;
        step(5);
        #1 chk(ti_o, ti1);
        $display("Test gain select done");
    endtask
    // Deviation switching: below, above, between, and clamped thresholds.
    task t_dev;
        int c[5][4] = '{'{500, 450, 200, 800}, '{100, 1000, 200, 800}, '{700, 200, 200, 800},
                        '{1000, 0, 0, 1023}, '{500, 350, 900, 800}};
        int d;
        for (int i = 0; i < 5; i++) begin
            step(1);
            cond <= 2'h2;
            sp <= 10'(c[i][0]);
            fb <= 10'(c[i][1]);
            lo <= 10'(c[i][2]);
            hi <= 10'(c[i][3]);
            step(2);
            d = (c[i][0] > c[i][1]) ? c[i][0] - c[i][1] : c[i][1] - c[i][0];
            #1 chk(kp_o, mixv(kp1, kp2, d, c[i][2], c[i][3]));
            chk(ti_o, mixv(ti1, ti2, d, c[i][2], c[i][3]));
        end
        $display("Test deviation done");
    endtask
    // Integral attribute digits against pause and limit.
    task t_integral;
        int r[5][5] = '{'{0, 1, 0, 1, 1}, '{1, 1, 0, 0, 0}, '{1, 0, 0, 1, 1}, '{16, 0, 1, 0, 1}, '{0, 0, 1, 1, 1}};
        for (int i = 0; i < 5; i++) begin
            step(1);
            run <= 1'b1;
            attr <= 8'(r[i][0]);
            preq <= r[i][1][0];
            lim <= r[i][2][0];
            step(5);
            #1 chk(16'(int_en), 16'(r[i][3]));
            chk(16'(int_use), 16'(r[i][4]));
        end
        $display("Test integral done");
    endtask
    // Start hold, stop selector and feedback loss.
    task t_run;
        step(1);
        run <= 1'b0;
        hold <= 16'h0003;
        iv <= 10'h1F4;
        step(3);
        #1 chk(16'(comp_en), 16'h0000);
        step(1);
        run <= 1'b1;
        step(6);
        #1 chk(16'(force_o), 16'h0001);
        chk(16'(force_v), 16'h01F4);
        step(16);
        #1 chk(16'(force_o), 16'h0000);
        step(1);
        run <= 1'b0;
        stsel <= 1'b1;
        fb <= 10'h000;
        step(40);
        #1 chk(16'(comp_en), 16'h0001);
        chk(16'(fault), 16'h0000);
        step(1);
        lvl <= 10'h064;
        fb <= 10'h032;
        step(8);
        #1 chk(16'(fault), 16'h0000);
        step(30);
        #1 chk(16'(fault), 16'h0001);
        $display("Test run and loss done");
    endtask

    // Watchdog well beyond the expected run length.
    initial begin
        step(3000);
        error_cnt++;
        give_verdict();
    end
    // Main sequence.
    initial begin
        t_reset();
        t_gains();
        t_dev();
        t_integral();
        t_run();
        t_reset();
        give_verdict();
    end
endmodule
